/* srap_pkg.sv */
// Constants, types and state codes shared by the serial register access port.
// Assumes a single 200 MHz core clock and an active high asynchronous reset.
// Operation
// - Status byte heads every SPI reply.
// - Fault and restart bits clear on read.
// - Register data right aligned, integer fields.
// - Select low, sample rise, drive fall, MSB.
// - Extra bits leave forty clocks later.
// - Select rise latches last forty bits.
// - Mode three, clock at most 10 MHz.
// - Input pulses under 10 ns ignored.
// - Serial clock independent of core clock; the code samples it with the core clock.
// - Write datagram is sixty-four bits.
// - Bit time measured from sync nibble.
// - Bytes framed by start, stop, LSB first.
// - Node address is base plus straps.
// - Index bit seven selects write.
// - Long gap resets, then twelve idle bits.
// - Glitch or CRC error forces idle timeout.
// - Accepted writes bump eight bit counter.
// - CRC poly 0x07, zero start, LSB first.
// - SPI address top bit marks write.
// - Reply carries previous read or write data.

package srap_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int FILTER_NS = 10;
  localparam int FILTER_CYC = (FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FILT_CNT_W = 2;
  localparam int PIN_COUNT = 4;
  localparam int GLITCH_CYC = 16;
  localparam int TIMEOUT_BITS = 63;
  localparam int RECOVER_BITS = 12;
  localparam int SYNC_MEASURE_SHIFT = 2;
  localparam logic [15:0] BITLEN_RST = 16'h0010;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int DIR_BIT = 39;
  localparam int IDX_MSB = 38;
  localparam int IDX_LSB = 32;
  localparam int UART_DIR_BIT = 7;
  localparam int STANDSTILL_BIT = 31;
  localparam int STALL_BIT = 24;
  localparam logic [7:0] SYNC_BYTE_PRELOAD = 8'hA0;
  localparam logic [3:0] SYNC_FIRST_BIT = 4'h3;
  localparam logic [1:0] SYNC_LAST_FALL = 2'h1;
  localparam logic [3:0] STOP_BIT_IDX = 4'h8;
  localparam logic [2:0] READ_LAST_BYTE = 3'h3;
  localparam logic [2:0] WRITE_LAST_BYTE = 3'h7;
  localparam logic [7:0] CRC_POLY = 8'h07;

  // ----------------------------------------
  // Register indices and reset values
  // ----------------------------------------
  localparam int REG_COUNT = 128;
  localparam logic [6:0] GLOBAL_STATUS_IDX = 7'h01;
  localparam logic [6:0] DRIVE_STATE_IDX = 7'h02;
  localparam logic [6:0] WRITE_ACK_IDX = 7'h03;
  localparam logic [6:0] NODE_BASE_IDX = 7'h04;
  localparam logic [1:0] GLOBAL_STATUS_RST = 2'h1;
  localparam logic [7:0] STATUS_RST = 8'h01;
  localparam logic [7:0] NODE_BASE_RST = 8'h00;

  // Receiver states of the one-wire line.
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_SYNC = 5'h02,
    RX_BITS = 5'h04,
    RX_WAIT = 5'h08,
    RX_RECOVER = 5'h10
  } srap_rx_state_t;

endpackage

/* srap_crc_if.sv */
// Carrier between the port core and its CRC step logic.
// Assumes the core drives the operands and reads the result in one cycle.
`timescale 1ns/10ps
`default_nettype none

interface srap_crc_if;
  logic [7:0] crcIn;  // Running CRC before this byte.
  logic [7:0] dataIn; // Byte to fold in, taken LSB first.
  logic [7:0] crcOut; // Running CRC after this byte.
  modport calc (input crcIn, input dataIn, output crcOut);
  modport user (output crcIn, output dataIn, input crcOut);
endinterface

`default_nettype wire

/* srap_crc8.sv */
// Byte-wide CRC step of the one-wire receiver.
// Assumes operands stable within one core clock cycle; no state.
`timescale 1ns/10ps
`default_nettype none

module srap_crc8 import srap_pkg::*; (
  srap_crc_if.calc crcBus
);

  // ----------------------------------------
  // Fold eight bits, least significant first
  // ----------------------------------------
  // CRC bit folding.
  always_comb begin
    logic [7:0] crcWork;
    crcWork = crcBus.crcIn;
    for (int i = 0; i < 8; i++) begin
      if (crcWork[7] ^ crcBus.dataIn[i]) begin
        crcWork = {crcWork[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        crcWork = {crcWork[6:0], 1'b0};
      end
    end
    crcBus.crcOut = crcWork;
  end

endmodule // srap_crc8

`default_nettype wire

/* srap_pin_filter.sv */
// Two-flop synchronisers and a short pulse filter for the external pins.
// Assumes idle-high pins; outputs start high under reset.
`timescale 1ns/10ps
`default_nettype none

module srap_pin_filter import srap_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [PIN_COUNT-1:0] pinRaw,
  output logic [PIN_COUNT-1:0] pinClean
);

  // All flops of the filter in one record.
  typedef struct packed {
    logic [PIN_COUNT-1:0] s1;
    logic [PIN_COUNT-1:0] s2;
    logic [PIN_COUNT-1:0] clean;
    logic [PIN_COUNT-1:0][FILT_CNT_W-1:0] cnt;
  } srap_filt_t;

  srap_filt_t st;
  srap_filt_t next_st;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // The first stage feeds only the second; the filter looks at stage two.
  always_comb begin
    next_st = st;
    next_st.s1 = pinRaw;
    next_st.s2 = st.s1;
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (st.s2[i] == st.clean[i]) begin
        next_st.cnt[i] = '0;
      end else if (st.cnt[i] == FILT_CNT_W'(FILTER_CYC - 1)) begin
        next_st.clean[i] = st.s2[i];
        next_st.cnt[i] = '0;
      end else begin
        next_st.cnt[i] = st.cnt[i] + FILT_CNT_W'(1);
      end
    end
  end

  // Lines idle high, so reset to high and avoid false edges at release.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '{s1: '1, s2: '1, clean: '1, cnt: '0};
    end else begin
      st <= next_st;
    end
  end

  assign pinClean = st.clean;

  // A change needs the new level on stage two for two cycles.
  filter_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    $changed(st.clean) |-> (((st.clean ^ $past(st.clean)) & ($past(st.s2) ^ st.clean))
      == '0) && (((st.clean ^ $past(st.clean)) & ($past(st.s2, 2) ^ st.clean)) == '0))
    else $error("filtered pin changed after a short pulse");

endmodule // srap_pin_filter

`default_nettype wire

/* srap_access_port.sv */
// Top of the serial register access port: SPI slave and one-wire UART receiver
// sharing one register set. Assumes one core clock; pins arrive asynchronously.
`timescale 1ns/10ps
`default_nettype none

module srap_access_port import srap_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic uartMode,
  input wire logic selectStrapBit2N,
  input wire logic clockStrapBit1,
  input wire logic inputStrapBit0,
  output logic serialDataOut,
  output logic serialDataOutEn,
  input wire logic oneWireDataPin,
  input wire logic motorStandstill,
  input wire logic stallDetectFlag,
  input wire logic bridgeFaultEvent,
  output logic regWriteStrobe,
  output logic [6:0] regWriteIndex,
  output logic [31:0] regWriteData,
  output logic [7:0] writeAckCount,
  output logic [7:0] nodeAddress
);

  // ----------------------------------------
  // State record
  // ----------------------------------------
  typedef struct packed {
    srap_rx_state_t rx;        // One-wire receiver state.
    logic [PIN_COUNT-1:0] prevPins; // Filtered pins one cycle back.
    logic [39:0] shreg;        // SPI shift register.
    logic sdo;                 // Serial data out flop.
    logic [31:0] reply;        // Data returned by the next SPI frame.
    logic [7:0] statusLat;     // Status byte latched at frame end.
    logic [1:0] globalStatusReg; // Fault and restart flags.
    logic [7:0] ackCnt;        // Accepted write datagrams.
    logic [7:0] nodeIdBase;    // Programmed node base.
    logic [2:0] strap;         // Address straps.
    logic [7:0] nodeAddr;      // Effective node address.
    logic [23:0] cnt;          // Measure, bit and idle timer.
    logic [23:0] gap;          // Cycles since last start bit.
    logic [15:0] bitLen;       // Measured bit period.
    logic [3:0] bitIdx;        // Bit within byte, eight is stop.
    logic [1:0] falls;         // Falling edges seen in sync.
    logic [7:0] byteSh;        // Byte being assembled.
    logic [2:0] byteIdx;       // Byte within datagram.
    logic [63:0] dg;           // Received bytes, first byte highest.
    logic [7:0] crc;           // Running CRC.
    logic wrStrobe;
    logic [6:0] wrIdx;
    logic [31:0] wrData;
  } srap_port_t;

  srap_port_t st;
  srap_port_t next_st;

  logic [31:0] regMem [REG_COUNT]; // Plain storage behind the register indices.
  logic [PIN_COUNT-1:0] pinClean;  // Synchronised, filtered pins.
  logic memWe;
  logic [6:0] memIdx;
  logic [31:0] memData;
  logic [31:0] rdData;
  logic errorEvt;    // One-wire framing, glitch, CRC or timeout error.
  logic acceptWr;    // Matching, valid write datagram.
  logic statusRead;  // SPI read of the global status register.
  logic lastByte;
  logic [23:0] timeoutLim;
  logic [23:0] recoverLim;

  // Pin aliases after filtering.
  wire logic selN = pinClean[0];
  wire logic sck = pinClean[1];
  wire logic sdi = pinClean[2];
  wire logic line = pinClean[3];
  wire logic spiOn = !uartMode;
  wire logic selFall = st.prevPins[0] && !selN;
  wire logic selRise = !st.prevPins[0] && selN;
  wire logic sckRise = !st.prevPins[1] && sck;
  wire logic sckFall = st.prevPins[1] && !sck;
  wire logic lineFall = st.prevPins[3] && !line;
  wire logic lineRise = !st.prevPins[3] && line;
  wire logic directionFlag = st.shreg[DIR_BIT];
  wire logic [6:0] cmdIdx = st.shreg[IDX_MSB:IDX_LSB];

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Serial clock sampled.
  // The serial clock is only ever sampled, and the output lags each fall by several core cycles, so it must run at 10 MHz at most.
  srap_pin_filter pinFilter (
    .core_clk (core_clk),
    .rst (rst),
    .pinRaw ({oneWireDataPin, inputStrapBit0, clockStrapBit1, selectStrapBit2N}),
    .pinClean (pinClean)
  );

  srap_crc_if crcBus ();
  assign crcBus.crcIn = st.crc;
  assign crcBus.dataIn = st.byteSh;

  srap_crc8 crcStep (
    .crcBus (crcBus.calc)
  );

  always_comb begin
    rdData = regMem[cmdIdx];
    case (cmdIdx)
      GLOBAL_STATUS_IDX: rdData = {30'h0000_0000, st.globalStatusReg};
      DRIVE_STATE_IDX: begin
        rdData = 32'h0000_0000;
        rdData[STANDSTILL_BIT] = motorStandstill;
        rdData[STALL_BIT] = stallDetectFlag;
      end
      WRITE_ACK_IDX: rdData = {24'h00_0000, st.ackCnt};
      NODE_BASE_IDX: rdData = {24'h00_0000, st.nodeIdBase};
      default: rdData = regMem[cmdIdx];
    endcase
  end

  // Idle limits scale with the measured bit period.
  assign timeoutLim = 24'(st.bitLen) * 24'(TIMEOUT_BITS);
  assign recoverLim = 24'(st.bitLen) * 24'(RECOVER_BITS);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // SPI and one-wire share the store; the mode pin keeps them apart.
  always_comb begin
    next_st = st;
    memWe = 1'b0;
    memIdx = cmdIdx;
    memData = st.shreg[31:0];
    errorEvt = 1'b0;
    acceptWr = 1'b0;
    statusRead = 1'b0;
    lastByte = 1'b0;
    next_st.prevPins = pinClean;

    if (spiOn && selFall) begin
      next_st.shreg = {st.statusLat, st.reply};
      next_st.sdo = st.statusLat[7];
    end else if (spiOn && !selN && sckRise) begin
      next_st.shreg = {st.shreg[38:0], sdi};
    end else if (spiOn && !selN && sckFall) begin
      next_st.sdo = st.shreg[DIR_BIT];
    end

    if (spiOn && selRise) begin
      if (directionFlag) begin
        memWe = 1'b1;
        next_st.reply = st.shreg[31:0];
      end else begin
        next_st.reply = rdData;
        statusRead = (cmdIdx == GLOBAL_STATUS_IDX);
      end
    end

    if (!uartMode) begin
      next_st.rx = RX_IDLE;
    end else begin
      next_st.strap = {selN, sck, sdi};
      case (st.rx)
        RX_IDLE: begin
          if (!line) begin
            next_st.rx = RX_SYNC;
            next_st.cnt = 24'h00_0001;
            next_st.falls = 2'h0;
            next_st.gap = 24'h00_0000;
          end
        end
        RX_SYNC: begin
          next_st.cnt = st.cnt + 24'h00_0001;
          if (lineRise && st.falls == 2'h0 && st.cnt < 24'(GLITCH_CYC)) begin
            errorEvt = 1'b1;
          end else if (lineFall) begin
            if (st.falls == SYNC_LAST_FALL) begin
              next_st.bitLen = 16'(st.cnt >> SYNC_MEASURE_SHIFT);
              next_st.cnt = 24'(next_st.bitLen >> 1);
              next_st.rx = RX_BITS;
              next_st.bitIdx = SYNC_FIRST_BIT;
              next_st.byteSh = SYNC_BYTE_PRELOAD;
              next_st.byteIdx = 3'h0;
              next_st.crc = 8'h00;
            end else begin
              next_st.falls = st.falls + 2'h1;
            end
          end else if (&st.cnt) begin
            errorEvt = 1'b1;
          end
        end
        RX_BITS: begin
          next_st.gap = st.gap + 24'h00_0001;
          if (st.cnt != 24'h00_0000) begin
            next_st.cnt = st.cnt - 24'h00_0001;
          end else if (st.bitIdx != STOP_BIT_IDX) begin
            next_st.byteSh = {line, st.byteSh[7:1]};
            next_st.bitIdx = st.bitIdx + 4'h1;
            next_st.cnt = 24'(st.bitLen) - 24'h00_0001;
          end else if (!line) begin
            errorEvt = 1'b1;
          end else begin
            next_st.dg = {st.dg[55:0], st.byteSh};
            lastByte = (st.byteIdx == WRITE_LAST_BYTE) ||
              (st.byteIdx == READ_LAST_BYTE && !st.dg[UART_DIR_BIT]);
            if (!lastByte) begin
              next_st.crc = crcBus.crcOut;
              next_st.byteIdx = st.byteIdx + 3'h1;
              next_st.rx = RX_WAIT;
            end else if (st.byteSh != st.crc) begin
              errorEvt = 1'b1;
            end else begin
              next_st.rx = RX_IDLE;
              if (st.byteIdx == WRITE_LAST_BYTE && st.dg[47:40] == st.nodeAddr) begin
                acceptWr = 1'b1;
                memWe = 1'b1;
                memIdx = st.dg[IDX_MSB:IDX_LSB];
                memData = st.dg[31:0];
              end
            end
          end
        end
        RX_WAIT: begin
          next_st.gap = st.gap + 24'h00_0001;
          if (lineFall) begin
            next_st.rx = RX_BITS;
            next_st.bitIdx = 4'h0;
            next_st.cnt = 24'(st.bitLen) + 24'(st.bitLen >> 1) - 24'h00_0001;
            next_st.gap = 24'h00_0000;
          end else if (st.gap >= timeoutLim) begin
            errorEvt = 1'b1;
          end
        end
        RX_RECOVER: begin
          if (!line) begin
            next_st.cnt = 24'h00_0000;
          end else if (st.cnt >= recoverLim) begin
            next_st.rx = RX_IDLE;
          end else begin
            next_st.cnt = st.cnt + 24'h00_0001;
          end
        end
        default: next_st.rx = RX_IDLE;
      endcase
      if (errorEvt) begin
        next_st.rx = RX_RECOVER;
        next_st.cnt = 24'h00_0000;
      end
    end

    if (acceptWr) begin
      next_st.ackCnt = st.ackCnt + 8'h01;
    end
    next_st.globalStatusReg[1] = (st.globalStatusReg[1] && !statusRead) || bridgeFaultEvent;
    next_st.globalStatusReg[0] = st.globalStatusReg[0] && !statusRead;
    if (spiOn && selRise) begin
      next_st.statusLat = {4'h0, motorStandstill, stallDetectFlag, next_st.globalStatusReg};
    end
    if (memWe && memIdx == NODE_BASE_IDX) begin
      next_st.nodeIdBase = memData[7:0];
    end
    next_st.nodeAddr = next_st.nodeIdBase + {5'h00, next_st.strap};
    next_st.wrStrobe = memWe;
    next_st.wrIdx = memIdx;
    next_st.wrData = memData;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.rx <= RX_IDLE;
      st.prevPins <= '1;
      st.statusLat <= STATUS_RST;
      st.globalStatusReg <= GLOBAL_STATUS_RST;
      st.nodeIdBase <= NODE_BASE_RST;
      st.nodeAddr <= NODE_BASE_RST;
      st.bitLen <= BITLEN_RST;
    end else begin
      st <= next_st;
    end
  end

  // Storage is not reset; software must write before it reads.
  always_ff @(posedge core_clk) begin
    if (memWe) begin
      regMem[memIdx] <= memData;
    end
  end

  assign serialDataOut = st.sdo;
  assign serialDataOutEn = spiOn && !selN;
  assign regWriteStrobe = st.wrStrobe;
  assign regWriteIndex = st.wrIdx;
  assign regWriteData = st.wrData;
  assign writeAckCount = st.ackCnt;
  assign nodeAddress = st.nodeAddr;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  status_byte_a: assert property (@(posedge core_clk) disable iff (rst)
    spiOn && selFall |=> st.shreg[39:36] == 4'h0 && st.shreg[35:32] == $past(st.statusLat[3:0]))
    else $error("status byte not loaded at select fall");

  spi_shift_a: assert property (@(posedge core_clk) disable iff (rst)
    spiOn && !selN && sckRise |=> st.shreg == {$past(st.shreg[38:0]), $past(sdi)})
    else $error("shift register missed a rising clock");

  sdo_edge_a: assert property (@(posedge core_clk) disable iff (rst)
    $changed(st.sdo) |-> $past(sckFall || selFall))
    else $error("serial output moved off a falling edge");

  write_echo_a: assert property (@(posedge core_clk) disable iff (rst)
    spiOn && selRise && directionFlag |=> st.reply == $past(st.shreg[31:0]) && st.wrStrobe)
    else $error("write frame not latched at select rise");

  status_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(st.globalStatusReg[1]) |-> $past(statusRead))
    else $error("fault flag cleared without a read");

  bit_time_a: assert property (@(posedge core_clk) disable iff (rst)
    uartMode && st.rx == RX_SYNC && lineFall && st.falls == SYNC_LAST_FALL && !errorEvt
    |=> st.bitLen == 16'($past(st.cnt) >> SYNC_MEASURE_SHIFT) && st.rx == RX_BITS)
    else $error("bit period not taken from sync");

  ack_count_a: assert property (@(posedge core_clk) disable iff (rst)
    $changed(st.ackCnt) |-> $past(acceptWr) && st.ackCnt == $past(st.ackCnt) + 8'h01)
    else $error("write counter moved without an accepted write");

  node_match_a: assert property (@(posedge core_clk) disable iff (rst)
    acceptWr |-> st.dg[47:40] == st.nodeAddr && st.byteSh == st.crc)
    else $error("write accepted for a foreign node or bad check");

  recover_entry_a: assert property (@(posedge core_clk) disable iff (rst)
    uartMode && errorEvt |=> st.rx == RX_RECOVER && st.cnt == 24'h00_0000)
    else $error("error did not start the idle timeout");

  recover_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    uartMode && st.rx == RX_RECOVER && !line |=> st.rx == RX_RECOVER)
    else $error("recovery left while the line was low");

endmodule // srap_access_port

`default_nettype wire

/* srap_host_model.sv */
// Host model: SPI mode-3 frames and one-wire UART write datagrams.
// Assumes the bench calls its tasks; the core clock paces all timing.
`timescale 1ns/10ps
`default_nettype none

module srap_host_model (
  input wire logic core_clk,
  input wire logic sdo,
  output logic csN,
  output logic sck,
  output logic sdi,
  output logic line
);
  localparam int HALF = 10; // Half serial period: 10 MHz at most.
  localparam int BITC = 32; // UART bit period, above the clock/16 floor.

  // ----------------------------------------
  // Idle levels: select high, clock high, line high.
  // ----------------------------------------
  initial begin
    csN = 1'b1;
    sck = 1'b1;
    sdi = 1'b0;
    line = 1'b1;
  end

  // Moves off the edge so the design never races the bench.
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Strap levels on the SPI pins while the one-wire mode is live.
  task automatic straps(input logic [2:0] s);
    csN = s[2];
    sck = s[1];
    sdi = s[0];
  endtask

  task automatic spi(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    csN = 1'b0;
    wt(HALF);
    for (int i = n - 1; i >= 0; i--) begin
      sck = 1'b0;
      sdi = tx[i];
      wt(HALF);
      sck = 1'b1;
      rx = {rx[62:0], sdo};
      wt(HALF);
    end
    csN = 1'b1;
    // Released data line shows no stale value.
    sdi = ~sdi;
    wt(4 * HALF);
  endtask

  task automatic ubyte(input logic [7:0] b);
    line = 1'b0;
    wt(BITC);
    for (int i = 0; i < 8; i++) begin
      line = b[i];
      wt(BITC);
    end
    line = 1'b1;
    wt(BITC);
  endtask

  // short low pulse on idle line
  task automatic glitch(input int n);
    line = 1'b0;
    wt(n);
    line = 1'b1;
    wt(BITC);
  endtask

  // datagram with CRC
  // A nonzero hold pauses after the fourth byte, to provoke the gap timeout.
  task automatic uwrite(input logic [7:0] node, input logic [7:0] idx,
                        input logic [31:0] d, input logic bad, input int hold);
    logic [55:0] m;
    logic [7:0] c;
    m = {8'h05, node, idx, d};
    c = '0;
    for (int i = 55; i >= 0; i -= 8) begin
      ubyte(m[i-:8]);
      for (int j = 0; j < 8; j++) begin
        c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i-7+j]) ? 8'h07 : 8'h00);
      end
      if (i == 31 && hold > 0) wt(hold);
    end
    // A flipped low bit stands for a corrupted checksum.
    ubyte(c ^ {7'h00, bad});
    wt(2 * BITC);
  endtask
endmodule // srap_host_model

`default_nettype wire

/* tb.sv */
// Self-checking bench of the serial register access port.
// Assumes the host model drives all pins; 200 MHz core clock.
`timescale 1ns/10ps
`default_nettype none

module tb;
  import srap_pkg::*;
  logic core_clk, rst, uartMode, standstill, stall, fault;
  logic csN, sck, sdi, line, sdo, sdoEn, wrStb;
  logic [6:0] wrIdxOut;
  logic [31:0] wrDataOut;
  logic [7:0] ackCount, nodeAddr;
  logic [63:0] rx;
  logic [6:0] wrIdx;
  logic [31:0] wrData;
  int wrCount, errCount, checks;

  srap_host_model hm (.core_clk(core_clk), .sdo(sdo), .csN(csN), .sck(sck),
    .sdi(sdi), .line(line));
  srap_access_port dut_u (.core_clk(core_clk), .rst(rst), .uartMode(uartMode),
    .selectStrapBit2N(csN), .clockStrapBit1(sck), .inputStrapBit0(sdi),
    .serialDataOut(sdo), .serialDataOutEn(sdoEn), .oneWireDataPin(line),
    .motorStandstill(standstill), .stallDetectFlag(stall),
    .bridgeFaultEvent(fault), .regWriteStrobe(wrStb), .regWriteIndex(wrIdxOut),
    .regWriteData(wrDataOut), .writeAckCount(ackCount), .nodeAddress(nodeAddr));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Captures every write the port reports.
  always @(posedge core_clk) begin
    if (wrStb === 1'b1) begin
      wrCount <= wrCount + 1;
      wrIdx <= wrIdxOut;
      wrData <= wrDataOut;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Bounded wait for the next reported write.
  task automatic waitWr(input int n0);
    for (int k = 0; k < 400 && wrCount == n0; k++) @(posedge core_clk);
    #1;
    check(wrCount, n0 + 1);
    if (wrCount == n0) final_report();
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    errCount++;
    final_report();
  end

  initial begin
    {wrCount, errCount, checks} = '0;
    {rst, uartMode, standstill, stall, fault} = 5'b10100;
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    hm.wt(4);
    hm.spi({24'h0, 8'h85, 32'h1234_5678}, 40, rx);
    waitWr(0);
    check(rx[39:32], 8'h01);
    check(wrIdx, 7'h05);
    check(wrData, 32'h1234_5678);
    $display("SPI write test done");
    fork
      hm.spi({24'h0, 8'h05, 32'h0}, 40, rx);
      begin
        hm.wt(100);
        check(sdoEn, 1'b1);
      end
    join
    check(sdoEn, 1'b0);
    check(rx[39:0], {8'h09, 32'h1234_5678});
    fault = 1'b1;
    stall = 1'b1;
    hm.wt(1);
    fault = 1'b0;
    hm.spi({24'h0, 8'h01, 32'h0}, 40, rx);
    check(rx[31:0], 32'h1234_5678);
    hm.spi({24'h0, 8'h00, 32'h0}, 40, rx);
    check(rx[39:0], {8'h0C, 32'h0000_0003});
    $display("SPI status test done");
    hm.spi({16'h0, 8'hA5, 8'h86, 32'hCAFE_0001}, 48, rx);
    waitWr(1);
    check(rx[7:0], 8'hA5);
    check({wrIdx, wrData}, {7'h06, 32'hCAFE_0001});
    $display("SPI chain test done");
    uartMode = 1'b1;
    hm.straps(3'b101);
    hm.wt(20);
    check(nodeAddr, 8'h05);
    hm.uwrite(8'h05, 8'h87, 32'hDEAD_BEEF, 1'b0, 0);
    waitWr(2);
    check({wrIdx, wrData}, {7'h07, 32'hDEAD_BEEF});
    check(ackCount, 8'h01);
    hm.uwrite(8'h04, 8'h87, 32'h0, 1'b0, 0);
    check(ackCount, 8'h01);
    hm.uwrite(8'h05, 8'h87, 32'h1, 1'b1, 0);
    check(ackCount, 8'h01);
    hm.wt(12 * 32);
    hm.uwrite(8'h05, 8'h88, 32'h0000_00FF, 1'b0, 0);
    check(ackCount, 8'h02);
    check({wrIdx, wrData}, {7'h08, 32'h0000_00FF});
    $display("UART test done");
    hm.glitch(8);
    hm.uwrite(8'h05, 8'h89, 32'h0000_0003, 1'b0, 0);
    check(ackCount, 8'h02);
    hm.wt(12 * 32);
    hm.uwrite(8'h05, 8'h8A, 32'h0000_0004, 1'b0, 0);
    check(ackCount, 8'h03);
    check({wrIdx, wrData}, {7'h0A, 32'h0000_0004});
    hm.uwrite(8'h05, 8'h8B, 32'h0000_0005, 1'b0, 2048);
    check(ackCount, 8'h03);
    $display("UART recovery test done");
    final_report();
  end
endmodule // tb

`default_nettype wire
